// File: sim/host_model.sv
// host model: drives the register strobe port of the led slot bank
// assumes strobes are driven at the falling edge of sys_clk
`timescale 1ns/100ps
`include "led_slot_regs.svh"
module host_model
(
  input wire logic sys_clk,
  output logic [7:0] reg_addr,
  output logic reg_wr,
  output logic [15:0] reg_wdata,
  output logic reg_rd,
  input wire logic [15:0] reg_rdata,
  input wire logic reg_hit
);
  // idle bus at time zero
  initial
  begin
    reg_addr = 8'h00;
    reg_wr = 1'b0;
    reg_wdata = 16'h0000;
    reg_rd = 1'b0;
  end
  // one-cycle write; released data is inverted so a stale word never matches
  task automatic wr(input logic [7:0] a, input logic [15:0] d);
    @(negedge sys_clk);
    reg_addr = a;
    reg_wdata = d;
    reg_wr = 1'b1;
    @(negedge sys_clk);
    reg_wr = 1'b0;
    reg_wdata = ~d;
  endtask : wr
  // read data is taken one cycle after the strobe edge
  task automatic rd(input logic [7:0] a, output logic [15:0] d, output logic h);
    @(negedge sys_clk);
    reg_addr = a;
    reg_rd = 1'b1;
    @(negedge sys_clk);
    reg_rd = 1'b0;
    reg_addr = ~a;
    d = reg_rdata;
    h = reg_hit;
  endtask : rd
  // write then read the same address on the very next cycle, as the strobe port allows
  task automatic wr_rd(input logic [7:0] a, input logic [15:0] w, output logic [15:0] d,
                       output logic h);
    @(negedge sys_clk);
    reg_addr = a;
    reg_wdata = w;
    reg_wr = 1'b1;
    @(negedge sys_clk);
    reg_wr = 1'b0;
    reg_wdata = ~w;
    reg_rd = 1'b1;
    @(negedge sys_clk);
    reg_rd = 1'b0;
    reg_addr = ~a;
    d = reg_rdata;
    h = reg_hit;
  endtask : wr_rd
  // start-up values; whole slots are switched off elsewhere, never by the led bits
  task automatic setup;
    wr(`ADDR_SLOT_A_LED_CONFIG, 16'h0319);
    wr(`ADDR_SLOT_B_LED_CONFIG, 16'h0319);
    wr(`ADDR_SLOT_A_PULSE_COUNT, 16'h0613);
    wr(`ADDR_SLOT_B_PULSE_COUNT, 16'h0613);
    wr(`ADDR_SLOT_LED_DISABLE, 16'h0000);
  endtask : setup
endmodule : host_model

// File: sim/tb_top.sv
// testbench for the led slot pulse configuration bank
// assumes the host model drives registers; slot strobes come from here
`timescale 1ns/100ps
`include "led_slot_regs.svh"
`define CHK(got, exp) begin num_checks++; if ((got) !== (exp)) begin n_fail++; \
  $display("CHECK FAILED at %0t: got %0h expected %0h", $time, got, exp); end end
module tb_top
  import led_slot_pkg::*;
;
  logic sys_clk = 1'b0;
  logic sys_rst = 1'b1;
  logic [7:0] reg_addr;
  logic reg_wr, reg_rd, reg_hit, first_led_scale = 1'b1, second_led_scale = 1'b0;
  logic [15:0] reg_wdata, reg_rdata, cfg_a, cfg_b, d;
  logic [3:0] first_led_coarse_code = 4'h5, second_led_coarse_code = 4'h0;
  slot_ctl_s slot_a_ctl = '0, slot_b_ctl = '0;
  slot_out_s slot_a_out, slot_b_out;
  drive_set_s first_led_driver, second_led_driver;
  logic h;
  int n_fail = 0, num_checks = 0, fires, act;
  logic [7:0] addrs [6] = '{`ADDR_LED_FINE_CURRENT, `ADDR_SLOT_A_LED_CONFIG,
    `ADDR_SLOT_A_PULSE_COUNT, `ADDR_SLOT_LED_DISABLE, `ADDR_SLOT_B_LED_CONFIG,
    `ADDR_SLOT_B_PULSE_COUNT};
  logic [15:0] rsts [6] = '{16'h630C, 16'h0320, 16'h0818, 16'h0000, 16'h0320, 16'h0818};

  // 25 ns clock
  initial
  begin
    forever #12.5 sys_clk = ~sys_clk;
  end

  led_slot_pulse_config i_dut (.sys_clk(sys_clk), .sys_rst(sys_rst), .reg_addr(reg_addr),
    .reg_wr(reg_wr), .reg_wdata(reg_wdata), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .reg_hit(reg_hit), .slot_a_ctl(slot_a_ctl), .slot_b_ctl(slot_b_ctl),
    .slot_a_out(slot_a_out), .slot_b_out(slot_b_out),
    .first_led_coarse_code(first_led_coarse_code), .first_led_scale(first_led_scale),
    .second_led_coarse_code(second_led_coarse_code), .second_led_scale(second_led_scale),
    .first_led_driver(first_led_driver), .second_led_driver(second_led_driver),
    .slot_a_led_config_out(cfg_a), .slot_b_led_config_out(cfg_b));
  host_model i_host (.sys_clk(sys_clk), .reg_addr(reg_addr), .reg_wr(reg_wr),
    .reg_wdata(reg_wdata), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .reg_hit(reg_hit));

  // verdict, reached from the tests or from the watchdog
  task final_report;
    $display("checks %0d mismatches %0d", num_checks, n_fail);
    if (n_fail == 0 && num_checks > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask : final_report

  // every register against its default, hit flag set
  task automatic check_defaults;
    for (int i = 0; i < 6; i++)
    begin
      i_host.rd(addrs[i], d, h);
      `CHK(d, rsts[i])
      `CHK(h, 1'b1)
    end
  endtask : check_defaults

  // peak in 10 nA units: coarse 0.1 mA steps, fine in thousandths, scale in tenths
  function automatic logic [31:0] peak_of(input int c, input int s, input int f);
    return (280 + 155 * c) * (710 + 24 * f) * (s ? 10 : 4);
  endfunction : peak_of

  // fine codes and coarse inputs, then both driver settings
  task automatic fine_case(input logic [15:0] w, input int c1, s1, c2, s2);
    first_led_coarse_code = 4'(c1);
    first_led_scale = 1'(s1);
    second_led_coarse_code = 4'(c2);
    second_led_scale = 1'(s2);
    i_host.wr(`ADDR_LED_FINE_CURRENT, w);
    repeat (2) @(negedge sys_clk);
    `CHK(first_led_driver.fine_mult, 11'(710 + 24 * w[4:0]))
    `CHK(second_led_driver.fine_mult, 11'(710 + 24 * w[10:6]))
    `CHK(first_led_driver.peak_target, 26'(peak_of(c1, s1, w[4:0])))
    `CHK(second_led_driver.peak_target, 26'(peak_of(c2, s2, w[10:6])))
  endtask : fine_case

  // one slot: start, then count+1 ticks back to back; counts fires and active cycles
  task automatic burst(input bit b, input int n);
    slot_ctl_s c;
    slot_out_s o;
    fires = 0;
    act = 0;
    for (int i = 0; i < n + 5; i++)
    begin
      @(negedge sys_clk);
      c.start = (i == 0);
      c.tick = (i > 0) && (i <= n + 1);
      if (b)
        slot_b_ctl = c;
      else
        slot_a_ctl = c;
      o = b ? slot_b_out : slot_a_out;
      fires += (o.fire === 1'b1);
      act += (o.driver_active === 1'b1);
    end
    `CHK(o, 2'b00)
  endtask : burst

  initial
  begin
    repeat (16) @(negedge sys_clk);
    sys_rst = 1'b0;
    check_defaults();
    `CHK(first_led_driver.fine_mult, 11'd998)
    `CHK(second_led_driver.fine_mult, 11'd998)
    `CHK({cfg_a, cfg_b}, 32'h03200320)
    $display("test defaults done");
    for (int i = 0; i < 6; i++)
      i_host.wr(addrs[i], ~rsts[i]);
    i_host.wr(8'h33, 16'hFFFF);
    i_host.rd(8'h33, d, h);
    `CHK({h, d}, 17'h00000)
    for (int i = 0; i < 6; i++)
    begin
      i_host.rd(addrs[i], d, h);
      `CHK(d, ~rsts[i])
    end
    i_host.wr_rd(`ADDR_SLOT_LED_DISABLE, 16'h5A3C, d, h);
    `CHK({h, d}, 17'h15A3C)
    $display("test readback done");
    i_host.setup();
    repeat (2) @(negedge sys_clk);
    `CHK({cfg_a, cfg_b}, 32'h03190319)
    fine_case(16'h60DF, 5, 1, 15, 1);
    fine_case(16'h6000, 5, 0, 0, 0);
    $display("test drivers done");
    i_host.wr(`ADDR_SLOT_A_PULSE_COUNT, 16'h0313);
    burst(1'b0, 3);
    `CHK({fires, act}, {32'd3, 32'd3})
    burst(1'b1, 6);
    `CHK({fires, act}, {32'd6, 32'd6})
    i_host.wr(`ADDR_SLOT_LED_DISABLE, 16'h0100);
    burst(1'b0, 3);
    `CHK({fires, act}, {32'd0, 32'd3})
    burst(1'b1, 6);
    `CHK({fires, act}, {32'd6, 32'd6})
    i_host.wr(`ADDR_SLOT_LED_DISABLE, 16'h0200);
    burst(1'b1, 6);
    `CHK({fires, act}, {32'd0, 32'd6})
    burst(1'b0, 3);
    `CHK({fires, act}, {32'd3, 32'd3})
    i_host.wr(`ADDR_SLOT_B_PULSE_COUNT, 16'h0013);
    burst(1'b1, 0);
    `CHK({fires, act}, {32'd0, 32'd0})
    $display("test pulses done");
    @(negedge sys_clk);
    sys_rst = 1'b1;
    repeat (2) @(negedge sys_clk);
    sys_rst = 1'b0;
    check_defaults();
    $display("test second reset done");
    final_report();
  end

  // watchdog: tests need well under 2000 cycles
  initial
  begin
    repeat (20000) @(posedge sys_clk);
    n_fail++;
    final_report();
  end
endmodule : tb_top

// File: src/led_slot_pkg.sv
// types shared by the led slot pulse configuration bank
// assumes nothing beyond the register header
package led_slot_pkg;

  // timing core request for one slot
  typedef struct packed {
    logic start;
    logic tick;
  } slot_ctl_s;

  // per-slot pulse drive result
  typedef struct packed {
    logic fire;
    logic driver_active;
  } slot_out_s;

  // analog setting handed to one led driver
  typedef struct packed {
    logic [10:0] fine_mult;
    logic [25:0] peak_target;
  } drive_set_s;

endpackage : led_slot_pkg

// File: src/led_slot_pulse_config.sv
// led drive configuration bank for the two measurement time slots, with
// the per-slot pulse counters and pulse suppression it steers
// assumes a serial control core that presents decoded register strobes,
// and a timing core that marks slot starts and pulse ticks
`timescale 1ns/100ps
`include "led_slot_regs.svh"

module led_slot_pulse_config
  import led_slot_pkg::*;
(
  input wire logic sys_clk,
  input wire logic sys_rst,
  input wire logic [7:0] reg_addr,
  input wire logic reg_wr,
  input wire logic [15:0] reg_wdata,
  input wire logic reg_rd,
  output logic [15:0] reg_rdata,
  output logic reg_hit,
  input wire slot_ctl_s slot_a_ctl,
  input wire slot_ctl_s slot_b_ctl,
  output slot_out_s slot_a_out,
  output slot_out_s slot_b_out,
  input wire logic [3:0] first_led_coarse_code,
  input wire logic first_led_scale,
  input wire logic [3:0] second_led_coarse_code,
  input wire logic second_led_scale,
  output drive_set_s first_led_driver,
  output drive_set_s second_led_driver,
  output logic [15:0] slot_a_led_config_out,
  output logic [15:0] slot_b_led_config_out
);

  // fine multiplier in thousandths
  function automatic logic [10:0] fine_mult_calc(input logic [4:0] code);
    logic [31:0] m;
    m = `FINE_BASE + `FINE_STEP * {27'h0, code};
    return m[10:0];
  endfunction : fine_mult_calc

  // peak target in units of 10 nA; 32 bits hold the worst case of about 38e6
  function automatic logic [25:0] peak_calc(input logic [3:0] coarse, input logic [4:0] fine,
                                            input logic scale);
    logic [31:0] c;
    logic [31:0] p;
    c = `COARSE_BASE + `COARSE_STEP * {28'h0, coarse};
    p = c * {21'h0, fine_mult_calc(fine)} * (scale ? `SCALE_HIGH : `SCALE_LOW);
    return p[25:0];
  endfunction : peak_calc

  logic [15:0] led_fine_current;
  logic [15:0] slot_a_led_config;
  logic [15:0] slot_a_pulse_count;
  logic [15:0] slot_led_disable;
  logic [15:0] slot_b_led_config;
  logic [15:0] slot_b_pulse_count;
  logic [7:0] remain_a;
  logic [7:0] remain_b;
  logic fire_a;
  logic fire_b;

  // address decode
  wire sel_fine = reg_addr == `ADDR_LED_FINE_CURRENT;
  wire sel_a_cfg = reg_addr == `ADDR_SLOT_A_LED_CONFIG;
  wire sel_a_cnt = reg_addr == `ADDR_SLOT_A_PULSE_COUNT;
  wire sel_dis = reg_addr == `ADDR_SLOT_LED_DISABLE;
  wire sel_b_cfg = reg_addr == `ADDR_SLOT_B_LED_CONFIG;
  wire sel_b_cnt = reg_addr == `ADDR_SLOT_B_PULSE_COUNT;
  wire addr_hit = sel_fine | sel_a_cfg | sel_a_cnt | sel_dis | sel_b_cfg | sel_b_cnt;

  // read selection; unmapped addresses read as zero
  wire [15:0] next_rdata = sel_fine ? led_fine_current :
                           sel_a_cfg ? slot_a_led_config :
                           sel_a_cnt ? slot_a_pulse_count :
                           sel_dis ? slot_led_disable :
                           sel_b_cfg ? slot_b_led_config :
                           sel_b_cnt ? slot_b_pulse_count : 16'h0000;

  // decoded fields
  wire [4:0] second_led_fine_code = led_fine_current[`SECOND_FINE_MSB:`SECOND_FINE_LSB];
  wire [4:0] first_led_fine_code = led_fine_current[`FIRST_FINE_MSB:`FIRST_FINE_LSB];
  wire [7:0] count_a = slot_a_pulse_count[`PULSE_COUNT_MSB:`PULSE_COUNT_LSB];
  wire [7:0] count_b = slot_b_pulse_count[`PULSE_COUNT_MSB:`PULSE_COUNT_LSB];
  wire slot_a_led_off = slot_led_disable[`SLOT_A_OFF_BIT];
  wire slot_b_led_off = slot_led_disable[`SLOT_B_OFF_BIT];

  // pulse sequencing keeps counting when the led is off, so slot timing is unchanged
  wire step_a = slot_a_ctl.tick && remain_a != 8'h00;
  wire step_b = slot_b_ctl.tick && remain_b != 8'h00;
  wire [7:0] next_remain_a = slot_a_ctl.start ? count_a : step_a ? remain_a - 8'h01 : remain_a;
  wire [7:0] next_remain_b = slot_b_ctl.start ? count_b : step_b ? remain_b - 8'h01 : remain_b;

  // register file; every bit is stored, reserved fields included
  always_ff @(posedge sys_clk)
  begin
    if (sys_rst)
    begin
      led_fine_current <= `RST_LED_FINE_CURRENT;
      slot_a_led_config <= `RST_LED_CONFIG;
      slot_a_pulse_count <= `RST_PULSE_COUNT;
      slot_led_disable <= `RST_SLOT_LED_DISABLE;
      slot_b_led_config <= `RST_LED_CONFIG;
      slot_b_pulse_count <= `RST_PULSE_COUNT;
    end
    else if (reg_wr)
    begin
      if (sel_fine) led_fine_current <= reg_wdata;
      if (sel_a_cfg) slot_a_led_config <= reg_wdata;
      if (sel_a_cnt) slot_a_pulse_count <= reg_wdata;
      if (sel_dis) slot_led_disable <= reg_wdata;
      if (sel_b_cfg) slot_b_led_config <= reg_wdata;
      if (sel_b_cnt) slot_b_pulse_count <= reg_wdata;
    end
  end

  // read data answers one cycle after the read strobe
  always_ff @(posedge sys_clk)
  begin
    if (sys_rst)
    begin
      reg_rdata <= 16'h0000;
      reg_hit <= 1'b0;
    end
    else if (reg_rd)
    begin
      reg_rdata <= next_rdata;
      reg_hit <= addr_hit;
    end
  end

  // pulse counters and current pulse gating
  always_ff @(posedge sys_clk)
  begin
    if (sys_rst)
    begin
      remain_a <= 8'h00;
      remain_b <= 8'h00;
      fire_a <= 1'b0;
      fire_b <= 1'b0;
    end
    else
    begin
      remain_a <= next_remain_a;
      remain_b <= next_remain_b;
      fire_a <= step_a && !slot_a_led_off;
      fire_b <= step_b && !slot_b_led_off;
    end
  end

  // drivers stay active for the whole burst whatever the disable bits say
  // each output struct has a single driver, so no member is written from two places
  assign slot_a_out = '{fire: fire_a, driver_active: remain_a != 8'h00};
  assign slot_b_out = '{fire: fire_b, driver_active: remain_b != 8'h00};

  // analog settings registered so the driver sees one clean update
  always_ff @(posedge sys_clk)
  begin
    if (sys_rst)
    begin
      first_led_driver <= '0;
      second_led_driver <= '0;
      slot_a_led_config_out <= `RST_LED_CONFIG;
      slot_b_led_config_out <= `RST_LED_CONFIG;
    end
    else
    begin
      first_led_driver.fine_mult <= fine_mult_calc(first_led_fine_code);
      second_led_driver.fine_mult <= fine_mult_calc(second_led_fine_code);
      first_led_driver.peak_target <= peak_calc(first_led_coarse_code, first_led_fine_code,
                                                first_led_scale);
      second_led_driver.peak_target <= peak_calc(second_led_coarse_code, second_led_fine_code,
                                                 second_led_scale);
      slot_a_led_config_out <= slot_a_led_config;
      slot_b_led_config_out <= slot_b_led_config;
    end
  end

  // checks

  property p_fine_reset;
    @(posedge sys_clk) $past(sys_rst) |-> led_fine_current == 16'h630C;
  endproperty
  a_fine_reset: assert property (p_fine_reset) else $error("fine current reset wrong");

  property p_second_fine_law;
    @(posedge sys_clk) disable iff (sys_rst)
      (reg_wr && sel_fine) ##1 !(reg_wr && sel_fine) |=>
      second_led_driver.fine_mult == 11'd710 + 11'd24 * {6'h0, $past(reg_wdata[10:6], 2)};
  endproperty
  a_second_fine_law: assert property (p_second_fine_law) else $error("second fine wrong");

  property p_first_fine_law;
    @(posedge sys_clk) disable iff (sys_rst)
      (reg_wr && sel_fine) ##1 !(reg_wr && sel_fine) |=>
      first_led_driver.fine_mult == 11'd710 + 11'd24 * {6'h0, $past(reg_wdata[4:0], 2)};
  endproperty
  a_first_fine_law: assert property (p_first_fine_law) else $error("first fine wrong");

  property p_config_reset;
    @(posedge sys_clk) $past(sys_rst) |->
      slot_a_led_config == 16'h0320 && slot_b_led_config == 16'h0320;
  endproperty
  a_config_reset: assert property (p_config_reset) else $error("config reset wrong");

  property p_count_reset;
    @(posedge sys_clk) $past(sys_rst) |->
      slot_a_pulse_count == 16'h0818 && slot_b_pulse_count == 16'h0818
      && slot_led_disable == 16'h0000;
  endproperty
  a_count_reset: assert property (p_count_reset) else $error("count reset wrong");

  property p_burst_load;
    @(posedge sys_clk) disable iff (sys_rst)
      slot_a_ctl.start && !(reg_wr && sel_a_cnt) |=> remain_a == $past(count_a);
  endproperty
  a_burst_load: assert property (p_burst_load) else $error("burst count not loaded");

  property p_b_fire_cause;
    @(posedge sys_clk) disable iff (sys_rst)
      slot_b_out.fire |-> $past(slot_b_ctl.tick) && $past(remain_b) != 8'h00;
  endproperty
  a_b_fire_cause: assert property (p_b_fire_cause) else $error("slot b stray pulse");

  property p_b_off;
    @(posedge sys_clk) disable iff (sys_rst) slot_b_led_off |=> !slot_b_out.fire;
  endproperty
  a_b_off: assert property (p_b_off) else $error("slot b pulsed while off");

  property p_a_off;
    @(posedge sys_clk) disable iff (sys_rst) slot_a_led_off |=> !slot_a_out.fire;
  endproperty
  a_a_off: assert property (p_a_off) else $error("slot a pulsed while off");

  property p_off_keeps_stepping;
    @(posedge sys_clk) disable iff (sys_rst)
      slot_a_led_off && step_a && !slot_a_ctl.start |=>
      remain_a == $past(remain_a) - 8'h01 && (remain_a == 8'h00 || slot_a_out.driver_active);
  endproperty
  a_off_keeps_stepping: assert property (p_off_keeps_stepping)
    else $error("disabled slot stopped sequencing");

  property p_peak;
    @(posedge sys_clk) disable iff (sys_rst)
      $stable(second_led_coarse_code) && $stable(second_led_scale)
      && $stable(led_fine_current) |=>
      second_led_driver.peak_target ==
      26'((32'h118 + 32'h9B * $past(second_led_coarse_code))
          * (32'h2C6 + 32'h18 * $past(second_led_fine_code))
          * ($past(second_led_scale) ? 32'hA : 32'h4));
  endproperty
  a_peak: assert property (p_peak) else $error("peak target wrong");

  property p_readback;
    @(posedge sys_clk) disable iff (sys_rst)
      reg_wr && sel_dis ##1 (reg_rd && !reg_wr && sel_dis) |=>
      reg_rdata == $past(reg_wdata, 2) && reg_hit;
  endproperty
  a_readback: assert property (p_readback) else $error("readback mismatch");

  c_full_burst_a: cover property (@(posedge sys_clk) disable iff (sys_rst)
    slot_a_ctl.start ##1 slot_a_out.driver_active [*6] ##1 !slot_a_out.driver_active);
  c_dark_level: cover property (@(posedge sys_clk) disable iff (sys_rst)
    slot_a_led_off && slot_b_led_off && step_a ##4 step_b);
  c_unmapped_read: cover property (@(posedge sys_clk) disable iff (sys_rst)
    reg_rd && !addr_hit);
  c_b_pulse: cover property (@(posedge sys_clk) disable iff (sys_rst) slot_b_out.fire);

endmodule : led_slot_pulse_config

// File: src/led_slot_regs.svh
// constants of the led slot pulse configuration register bank
// assumes an 8-bit register address and 16-bit register data
`ifndef LED_SLOT_REGS_SVH
`define LED_SLOT_REGS_SVH

// register addresses
`define ADDR_LED_FINE_CURRENT 8'h25
`define ADDR_SLOT_A_LED_CONFIG 8'h30
`define ADDR_SLOT_A_PULSE_COUNT 8'h31
`define ADDR_SLOT_LED_DISABLE 8'h34
`define ADDR_SLOT_B_LED_CONFIG 8'h35
`define ADDR_SLOT_B_PULSE_COUNT 8'h36

// reset values
`define RST_LED_FINE_CURRENT 16'h630C
`define RST_LED_CONFIG 16'h0320
`define RST_PULSE_COUNT 16'h0818
`define RST_SLOT_LED_DISABLE 16'h0000

// field positions
`define SECOND_FINE_MSB 10
`define SECOND_FINE_LSB 6
`define FIRST_FINE_MSB 4
`define FIRST_FINE_LSB 0
`define PULSE_COUNT_MSB 15
`define PULSE_COUNT_LSB 8
`define SLOT_B_OFF_BIT 9
`define SLOT_A_OFF_BIT 8

// current law, fixed point: coarse in 0.1 mA, fine in 0.001, scale in 0.1
`define COARSE_BASE 32'h118
`define COARSE_STEP 32'h9B
`define FINE_BASE 32'h2C6
`define FINE_STEP 32'h18
`define SCALE_LOW 32'h4
`define SCALE_HIGH 32'hA

`endif
